// File: logic/scf_pkg.sv
// Shared constants for the smart card queue, lamp and filter registers
package scf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] SCF_IDX_CFG = 8'h26;
  localparam logic [7:0] SCF_IDX_LAMP = 8'h27;
  localparam logic [7:0] SCF_IDX_THR_LO = 8'h28;
  localparam logic [7:0] SCF_IDX_THR_HI = 8'h29;
  localparam logic [7:0] SCF_IDX_LVL_LO = 8'h2A;
  localparam logic [7:0] SCF_IDX_LVL_HI = 8'h2B;
  localparam logic [7:0] SCF_IDX_FILT = 8'h2C;
  localparam int SCF_ADDR_W = 10;

  // Lamp control field layout
  localparam int SCF_LAMP_SRC_BIT = 2;
  localparam int SCF_LAMP_PAT_LSB = 0;
  localparam int SCF_LAMP_W = 3;

  // Reset values, plus the configuration read value and the 256 filter count
  localparam logic [7:0] SCF_CFG_VALUE = 8'h00;
  localparam logic [2:0] SCF_LAMP_RST = 3'h0;
  localparam logic [15:0] SCF_THR_RST = 16'h0000;
  localparam logic [15:0] SCF_LVL_RST = 16'h0000;
  localparam logic [8:0] SCF_FILT_RST = 9'h000;
  localparam logic [8:0] SCF_FILT_FULL = 9'h100;

  // Lamp patterns
  typedef enum logic [1:0] {
    SCF_PAT_OFF = 2'h0,
    SCF_PAT_1HZ = 2'h1,
    SCF_PAT_HALF_HZ = 2'h2,
    SCF_PAT_ON = 2'h3
  } scf_pat_t;

  // Transmit tracking states, Gray along idle-run-halt
  typedef enum logic [1:0] {
    SCF_TX_IDLE = 2'h0,
    SCF_TX_RUN = 2'h1,
    SCF_TX_HALT = 2'h3
  } scf_tx_t;

  // Timing
  localparam int SCF_CLK_HZ = 100_000_000;
  localparam int SCF_LAMP_PHASE_MS = 500;
  localparam int SCF_FAST_RATE_DHZ = 55;
  localparam int SCF_SLOW_PHASE_CYC = SCF_CLK_HZ / 1000 * SCF_LAMP_PHASE_MS;
  localparam int SCF_FAST_HALF_CYC =
    SCF_CLK_HZ / (2 * SCF_FAST_RATE_DHZ) * 10;
  localparam int SCF_DIV_W = 27;
endpackage

// File: logic/scf_regs.sv
// Smart card lamp, queue level, threshold and filter length registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

// How it works
// (R1) Configuration block register always reads zero
// (R2) Lamp source bit: field, or activity blink
// (R3) Pattern 00 off, 01 1Hz, 11 on
// (R4) Pattern 10 lit 0.5s, dark 1.5s
// (R5) Interrupt when received level exceeds threshold
// (R6) Timer expiry also raises threshold interrupt; the code counts timeout expiry only in T0 mode
// (R7) Transmit length is level at go
// (R8) Level register always tracks bytes held
// (R9) Transmit error halts; level keeps remainder
// (R10) Queue flush clears level registers to zero
// (R11) Threshold compared only while receiver active
// (R12) Error flag shows transmit or receive phase
// (R13) Filter length decremented by outgoing filter
// (R14) Outgoing start with zero means 256
// (R15) Incoming start with zero means none
// (R16) Filter length read returns live count
// (R17) Threshold and level are 16-bit pairs
module scf_regs #(
  parameter int CNT_W = 16,
  parameter int SLOW_PHASE_CYC = scf_pkg::SCF_SLOW_PHASE_CYC,
  parameter int FAST_HALF_CYC = scf_pkg::SCF_FAST_HALF_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scf_pkg::SCF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_io_line,
  output logic lamp_out,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [7:0] rx_in_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic [7:0] rx_out_data,
  input wire logic tx_load,
  input wire logic tx_send,
  input wire logic host_read,
  input wire logic transmit_go_bit,
  input wire logic queue_flush_bit,
  input wire logic tx_error,
  input wire logic rx_error,
  input wire logic rx_active,
  input wire logic t0_mode,
  input wire logic cwt_expire,
  input wire logic tmo_expire,
  input wire logic filt_out_start,
  input wire logic filt_in_start,
  input wire logic filt_byte,
  output logic thresh_irq,
  output logic tx_phase_error_flag,
  output logic tx_busy,
  output logic [CNT_W-1:0] tx_length,
  output logic [8:0] filter_byte_count
);
  import scf_pkg::*;

  // Bus slave
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic setup, wr_en, hit;
  logic [7:0] idx;
  logic [2:0] lamp_q, lamp_d;
  logic [CNT_W-1:0] thr_q, thr_d, lvl_q, lvl_d, tx_len_q, tx_len_d;
  logic [8:0] filt_q, filt_d;
  logic irq_q, irq_d, expire_q, expire_d, err_tx_q, err_tx_d;
  // Busy kept as its own flop so the output needs no state decode
  logic busy_q, busy_d;
  scf_tx_t tx_q, tx_d;

  assign setup = psel && !penable;
  // Write lands at the edge that ends the single access cycle
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign idx = paddr[SCF_ADDR_W-1:2];
  assign hit = paddr[1:0] == 2'h0 && idx >= SCF_IDX_CFG &&
               idx <= SCF_IDX_FILT;

  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !hit;
    prdata_d = 32'h0000_0000;
    // Taken at setup so the data stands through the access cycle
    if (setup && !pwrite) begin
      unique case (idx)
        SCF_IDX_CFG: prdata_d[7:0] = SCF_CFG_VALUE; // [R1]
        SCF_IDX_LAMP: prdata_d[SCF_LAMP_W-1:0] = lamp_q;
        SCF_IDX_THR_LO: prdata_d[7:0] = thr_q[7:0]; // [R17]
        SCF_IDX_THR_HI: prdata_d[7:0] = thr_q[15:8];
        SCF_IDX_LVL_LO: prdata_d[7:0] = lvl_q[7:0]; // [R8]
        SCF_IDX_LVL_HI: prdata_d[7:0] = lvl_q[15:8];
        SCF_IDX_FILT: prdata_d[7:0] = filt_q[7:0]; // [R16]
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Lamp control and threshold registers
  always_comb begin
    lamp_d = lamp_q;
    thr_d = thr_q;
    if (wr_en && idx == SCF_IDX_LAMP)
      lamp_d = pwdata[SCF_LAMP_W-1:0];
    if (wr_en && idx == SCF_IDX_THR_LO)
      thr_d[7:0] = pwdata[7:0]; // [R17]
    if (wr_en && idx == SCF_IDX_THR_HI)
      thr_d[15:8] = pwdata[7:0];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lamp_q <= SCF_LAMP_RST;
      thr_q <= SCF_THR_RST;
    end else begin
      lamp_q <= lamp_d;
      thr_q <= thr_d;
    end
  end

  // Two-entry receive buffer; head is what the queue sees
  logic [7:0] head_q, head_d, tail_q, tail_d;
  logic [1:0] fill_q, fill_d;
  logic in_rdy_q, in_rdy_d, out_vld_q, out_vld_d;
  logic push, pop;

  assign push = rx_in_valid && in_rdy_q;
  assign pop = out_vld_q && rx_out_ready;

  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    fill_d = fill_q;
    unique case ({push, pop})
      2'b10: begin
        if (fill_q == 2'h0)
          head_d = rx_in_data;
        else
          tail_d = rx_in_data;
        fill_d = fill_q + 2'h1;
      end
      2'b01: begin
        head_d = tail_q;
        fill_d = fill_q - 2'h1;
      end
      2'b11: begin
        if (fill_q == 2'h1)
          head_d = rx_in_data;
        else begin
          head_d = tail_q;
          tail_d = rx_in_data;
        end
      end
      default: fill_d = fill_q;
    endcase
    // Flush drops bytes in flight so the level restarts clean
    if (queue_flush_bit)
      fill_d = 2'h0;
    in_rdy_d = fill_d != 2'h2;
    out_vld_d = fill_d != 2'h0;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      head_q <= 8'h00;
      tail_q <= 8'h00;
      fill_q <= 2'h0;
      in_rdy_q <= 1'b0;
      out_vld_q <= 1'b0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      fill_q <= fill_d;
      in_rdy_q <= in_rdy_d;
      out_vld_q <= out_vld_d;
    end
  end

  // Queue level, transmit tracking and threshold interrupt
  logic inc, dec, thr_wr;

  always_comb begin
    tx_d = tx_q;
    tx_len_d = tx_len_q;
    err_tx_d = err_tx_q;
    unique case (tx_q)
      SCF_TX_IDLE: begin
        if (transmit_go_bit && !queue_flush_bit) begin
          tx_d = SCF_TX_RUN;
          tx_len_d = lvl_q; // [R7]
        end
      end
      SCF_TX_RUN: begin
        if (tx_error)
          tx_d = SCF_TX_HALT; // [R9]
        else if (tx_send && lvl_q == {{(CNT_W-1){1'b0}}, 1'b1})
          tx_d = SCF_TX_IDLE;
      end
      SCF_TX_HALT: tx_d = SCF_TX_HALT;
      default: tx_d = SCF_TX_IDLE;
    endcase
    if (queue_flush_bit)
      tx_d = SCF_TX_IDLE; // [R10]
    busy_d = tx_d == SCF_TX_RUN;
    // A transmit error outranks a receive error in the same cycle
    if (tx_error)
      err_tx_d = 1'b1; // [R12]
    else if (rx_error)
      err_tx_d = 1'b0;
  end

  // Sends only count while running, so sends during a halt leave the level alone
  assign inc = tx_load || pop;
  assign dec = (tx_send && tx_q == SCF_TX_RUN && !tx_error) ||
               (host_read && lvl_q != SCF_LVL_RST);
  assign thr_wr = wr_en &&
                  (idx == SCF_IDX_THR_LO || idx == SCF_IDX_THR_HI);

  always_comb begin
    lvl_d = lvl_q;
    if (queue_flush_bit)
      lvl_d = SCF_LVL_RST; // [R10]
    else if (inc && !dec)
      lvl_d = lvl_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [R8]
    else if (dec && !inc)
      lvl_d = lvl_q - {{(CNT_W-1){1'b0}}, 1'b1}; // [R8] [R9]
    // Sticky until a threshold write or a flush
    expire_d = expire_q;
    if (thr_wr || queue_flush_bit)
      expire_d = 1'b0;
    // Expiry set wins over the acknowledging write
    if (cwt_expire || (tmo_expire && t0_mode))
      expire_d = 1'b1; // [R6]
    irq_d = expire_d || (rx_active && lvl_d > thr_d); // [R5] [R11]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_q <= SCF_TX_IDLE;
      tx_len_q <= SCF_LVL_RST;
      lvl_q <= SCF_LVL_RST;
      err_tx_q <= 1'b0;
      busy_q <= 1'b0;
      expire_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      tx_len_q <= tx_len_d;
      lvl_q <= lvl_d;
      err_tx_q <= err_tx_d;
      busy_q <= busy_d;
      expire_q <= expire_d;
      irq_q <= irq_d;
    end
  end

  // Filter length counter; bit 8 only holds the 256 case
  always_comb begin
    filt_d = filt_q;
    if (wr_en && idx == SCF_IDX_FILT)
      filt_d = {1'b0, pwdata[7:0]};
    else if (filt_out_start)
      filt_d = (filt_q[7:0] == 8'h00) ? SCF_FILT_FULL : filt_q; // [R14]
    else if (filt_in_start)
      filt_d = {1'b0, filt_q[7:0]}; // [R15]
    else if (filt_byte && filt_q != SCF_FILT_RST)
      filt_d = filt_q - 9'h001; // [R13]
  end

  always_ff @(posedge mclk) begin
    if (srst)
      filt_q <= SCF_FILT_RST;
    else
      filt_q <= filt_d;
  end

  // Lamp: card line synchroniser and activity window
  logic io_s1_q, io_s2_q, io_s3_q, act_edge;
  logic [SCF_DIV_W-1:0] slow_q, slow_d, fast_q, fast_d, act_q, act_d;
  logic [1:0] phase_q, phase_d;
  logic blink_q, blink_d, lamp_out_q, lamp_out_d, phase_en, fast_en;

  always_ff @(posedge mclk) begin
    if (srst) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
      io_s3_q <= 1'b1;
    end else begin
      io_s1_q <= card_io_line;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end

  // Third flop only keeps the settled level; idle reset avoids a false edge
  assign act_edge = io_s2_q != io_s3_q;
  assign phase_en = slow_q == SCF_DIV_W'(SLOW_PHASE_CYC - 1);
  assign fast_en = fast_q == SCF_DIV_W'(FAST_HALF_CYC - 1);

  always_comb begin
    slow_d = phase_en ? '0 : slow_q + SCF_DIV_W'(1);
    phase_d = phase_en ? phase_q + 2'h1 : phase_q;
    fast_d = fast_en ? '0 : fast_q + SCF_DIV_W'(1);
    blink_d = fast_en ? !blink_q : blink_q;
    // Activity holds one full fast period after the last edge
    if (act_edge)
      act_d = SCF_DIV_W'(2 * FAST_HALF_CYC);
    else if (act_q != '0)
      act_d = act_q - SCF_DIV_W'(1);
    else
      act_d = act_q;
    if (lamp_q[SCF_LAMP_SRC_BIT])
      lamp_out_d = act_q != '0 && blink_q; // [R2]
    else begin
      unique case (scf_pat_t'(lamp_q[SCF_LAMP_PAT_LSB +: 2]))
        SCF_PAT_OFF: lamp_out_d = 1'b0; // [R3]
        SCF_PAT_1HZ: lamp_out_d = !phase_q[0]; // [R3]
        SCF_PAT_HALF_HZ: lamp_out_d = phase_q == 2'h0; // [R4]
        SCF_PAT_ON: lamp_out_d = 1'b1; // [R3]
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      slow_q <= '0;
      phase_q <= 2'h0;
      fast_q <= '0;
      blink_q <= 1'b0;
      act_q <= '0;
      lamp_out_q <= 1'b0;
    end else begin
      slow_q <= slow_d;
      phase_q <= phase_d;
      fast_q <= fast_d;
      blink_q <= blink_d;
      act_q <= act_d;
      lamp_out_q <= lamp_out_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lamp_out = lamp_out_q;
  assign rx_in_ready = in_rdy_q;
  assign rx_out_valid = out_vld_q;
  assign rx_out_data = head_q;
  assign thresh_irq = irq_q;
  assign tx_phase_error_flag = err_tx_q;
  assign tx_busy = busy_q;
  assign tx_length = tx_len_q;
  assign filter_byte_count = filt_q;
endmodule

// File: dv/scf_card_model.sv
// Card side of the I/O line for the lamp activity tests
`timescale 1ns/1ps
module scf_card_model (
  input wire logic mclk,
  input wire logic talk,
  output logic io
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    io = 1'h1;
  end
  // Released line rests at its pull-up level
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    if (!talk) io <= 1'h1;
    else if (div_q == 2'h3) io <= !io;
  end
endmodule

// File: dv/scf_regs_sva.sv
// Checker for the queue, lamp and filter register block
`timescale 1ns/1ps
module scf_regs_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scf_pkg::SCF_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_error,
  input wire logic rx_error,
  input wire logic cwt_expire,
  input wire logic tmo_expire,
  input wire logic t0_mode,
  input wire logic filt_byte,
  input wire logic filt_in_start,
  input wire logic filt_out_start,
  input wire logic queue_flush_bit,
  input wire logic thresh_irq,
  input wire logic tx_phase_error_flag,
  input wire logic tx_busy,
  input wire logic [8:0] filter_byte_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence cfg_rd_s;
    setup_s ##0 (!pwrite && paddr == 10'h098);
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  cfg_zero_a: assert property (cfg_rd_s |=> prdata == 32'h0)
    else $error("config block not zero");
  tx_halt_a: assert property (tx_error |=> !tx_busy)
    else $error("transmit kept running");
  err_tx_a: assert property (tx_error |=> tx_phase_error_flag)
    else $error("transmit error not flagged");
  err_rx_a: assert property (rx_error && !tx_error |=>
    !tx_phase_error_flag) else $error("receive error flagged");
  expiry_irq_a: assert property (cwt_expire || t0_mode && tmo_expire
    |=> thresh_irq) else $error("expiry without interrupt");
  flush_idle_a: assert property (queue_flush_bit |=> !tx_busy)
    else $error("flush left transmit busy");
  in_zero_a: assert property (filt_in_start |=> !filter_byte_count[8])
    else $error("incoming start above 255");
  filt_dec_a: assert property (filt_byte && !psel && !filt_in_start &&
    !filt_out_start && filter_byte_count != 9'h000 |=>
    filter_byte_count == $past(filter_byte_count) - 9'h001)
    else $error("filter count not decremented");
endmodule
bind scf_regs scf_regs_sva u_sva (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_error(tx_error),
  .rx_error(rx_error), .cwt_expire(cwt_expire), .tmo_expire(tmo_expire),
  .t0_mode(t0_mode), .filt_byte(filt_byte), .filt_in_start(filt_in_start),
  .filt_out_start(filt_out_start), .queue_flush_bit(queue_flush_bit),
  .thresh_irq(thresh_irq), .tx_phase_error_flag(tx_phase_error_flag),
  .tx_busy(tx_busy), .filter_byte_count(filter_byte_count));

// File: dv/scf_regs_bench.sv
// Self-checking bench for the queue, lamp and filter register block
`timescale 1ns/1ps
module scf_regs_bench;
  import scf_pkg::*;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  logic [7:0] rx_in_data, rx_out_data;
  logic rx_active, t0_mode, talk, io, lamp_out, irq, eflag, busy;
  logic [15:0] tx_len;
  logic [8:0] fcnt;
  logic [11:0] ev;
  int n_errors = 0, checked = 0, cyc = 0;
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  scf_card_model u_card (.mclk(mclk), .talk(talk), .io(io));
  // Short lamp phases keep the blink checks within a few hundred cycles
  scf_regs #(.SLOW_PHASE_CYC(20), .FAST_HALF_CYC(6)) u_dut (.mclk(mclk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_io_line(io), .lamp_out(lamp_out),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data),
    .tx_load(ev[0]), .tx_send(ev[1]), .transmit_go_bit(ev[2]),
    .queue_flush_bit(ev[3]), .tx_error(ev[4]), .rx_error(ev[5]),
    .cwt_expire(ev[6]), .tmo_expire(ev[7]), .filt_out_start(ev[8]),
    .filt_in_start(ev[9]), .filt_byte(ev[10]), .host_read(ev[11]),
    .rx_active(rx_active), .t0_mode(t0_mode), .thresh_irq(irq),
    .tx_phase_error_flag(eflag), .tx_busy(busy), .tx_length(tx_len),
    .filter_byte_count(fcnt));
  task report_and_stop();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'h1, {i, 2'h0}, {24'h0, d});
  endtask
  task rr(input logic [7:0] i);
    apb(1'h0, {i, 2'h0}, 32'h0);
  endtask
  task pulse(input int b);
    ev[b] <= 1'h1;
    @(posedge mclk);
    ev[b] <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask
  task push(input logic [7:0] d);
    rx_in_valid <= 1'h1;
    rx_in_data <= d;
    @(posedge mclk);
    while (rx_in_ready !== 1'h1) @(posedge mclk);
    rx_in_valid <= 1'h0;
    @(posedge mclk);
  endtask
  task lamp(input int n, input int e);
    int k;
    k = 0;
    repeat (2) @(posedge mclk);
    repeat (n) begin
      @(posedge mclk);
      if (lamp_out === 1'h1) k++;
    end
    chk("lamp", e, k);
  endtask
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'h1;
    {rx_in_valid, rx_in_data, rx_out_ready, t0_mode, talk, ev} = '0;
    rx_active = 1'h1;
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    for (logic [7:0] i = 8'h26; i <= 8'h2C; i++) begin
      rr(i);
      chk("reset", 0, rd);
    end
    apb(1'h0, 10'h000, 32'h0);
    chk("unmapped", 1, er);
    wr(SCF_IDX_CFG, 8'hFF);
    rr(SCF_IDX_CFG);
    chk("cfg", 0, rd);
    wr(SCF_IDX_FILT, 8'h00);
    pulse(8);
    chk("filt out", 9'h100, fcnt);
    pulse(10);
    rr(SCF_IDX_FILT);
    chk("filt rd", 8'hFF, rd);
    wr(SCF_IDX_FILT, 8'h00);
    pulse(9);
    chk("filt in", 0, fcnt);
    wr(SCF_IDX_FILT, 8'h05);
    pulse(10);
    rr(SCF_IDX_FILT);
    chk("filt dec", 4, rd);
    wr(SCF_IDX_THR_LO, 8'h02);
    push(8'hA1);
    push(8'hB2);
    repeat (2) @(posedge mclk);
    chk("in ready", 0, rx_in_ready);
    chk("out valid", 1, rx_out_valid);
    chk("out data", 8'hA1, rx_out_data);
    rx_out_ready <= 1'h1;
    push(8'hC3);
    repeat (4) @(posedge mclk);
    rr(SCF_IDX_LVL_LO);
    chk("level", 3, rd);
    chk("out valid", 0, rx_out_valid);
    rr(SCF_IDX_LVL_HI);
    chk("level hi", 0, rd);
    chk("irq", 1, irq);
    wr(SCF_IDX_THR_LO, 8'h03);
    repeat (2) @(posedge mclk);
    chk("irq", 0, irq);
    wr(SCF_IDX_THR_LO, 8'h00);
    wr(SCF_IDX_THR_HI, 8'h01);
    rr(SCF_IDX_THR_HI);
    chk("thr hi", 1, rd);
    chk("irq", 0, irq);
    wr(SCF_IDX_THR_HI, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq", 1, irq);
    pulse(11);
    rr(SCF_IDX_LVL_LO);
    chk("level", 2, rd);
    rx_active <= 1'h0;
    wr(SCF_IDX_THR_LO, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq", 0, irq);
    pulse(6);
    chk("irq", 1, irq);
    pulse(3);
    rr(SCF_IDX_LVL_LO);
    chk("flush", 0, rd);
    pulse(7);
    chk("irq", 0, irq);
    t0_mode <= 1'h1;
    pulse(7);
    chk("irq", 1, irq);
    pulse(3);
    repeat (4) pulse(0);
    chk("irq", 0, irq);
    pulse(2);
    chk("length", 4, tx_len);
    chk("busy", 1, busy);
    pulse(1);
    rr(SCF_IDX_LVL_LO);
    chk("level", 3, rd);
    pulse(4);
    chk("busy", 0, busy);
    chk("eflag", 1, eflag);
    pulse(1);
    rr(SCF_IDX_LVL_LO);
    chk("level", 3, rd);
    pulse(3);
    rr(SCF_IDX_LVL_LO);
    chk("level", 0, rd);
    pulse(5);
    chk("eflag", 0, eflag);
    pulse(0);
    pulse(2);
    chk("length", 1, tx_len);
    pulse(1);
    chk("busy", 0, busy);
    rr(SCF_IDX_LVL_LO);
    chk("level", 0, rd);
    wr(SCF_IDX_LAMP, 8'h03);
    lamp(10, 10);
    wr(SCF_IDX_LAMP, 8'h00);
    lamp(10, 0);
    wr(SCF_IDX_LAMP, 8'h01);
    lamp(160, 80);
    wr(SCF_IDX_LAMP, 8'h02);
    lamp(160, 40);
    wr(SCF_IDX_LAMP, 8'h04);
    talk <= 1'h1;
    repeat (30) @(posedge mclk);
    lamp(96, 48);
    talk <= 1'h0;
    repeat (40) @(posedge mclk);
    lamp(20, 0);
    report_and_stop();
  end
endmodule
